/* File: pkg/asp_pkg.sv */
// constants, field layout and state codes of the second serial port
// assumes a byte-wide register port with three address bits
package asp_pkg;

  // register offsets
  localparam logic [2:0] OFS_DATA   = 3'h0;
  localparam logic [2:0] OFS_CTRL   = 3'h1;
  localparam logic [2:0] OFS_FMT    = 3'h2;
  localparam logic [2:0] OFS_BAUD   = 3'h3;
  localparam logic [2:0] OFS_RLD_LO = 3'h4;
  localparam logic [2:0] OFS_RLD_HI = 3'h5;

  // port_control_status bit positions
  localparam int CTL_RX_AVAIL = 0;
  localparam int CTL_TX_DONE  = 1;
  localparam int CTL_RX_EN    = 2;
  localparam int CTL_TX_XBIT  = 3;
  localparam int CTL_RX_XBIT  = 4;
  localparam int CTL_PAR_ERR  = 5;
  localparam int CTL_OVERRUN  = 6;
  localparam int CTL_IRQ_EN   = 7;

  // frame_format_config bit positions
  localparam int FMT_LEN_LSB   = 0;
  localparam int FMT_PAR_EN    = 2;
  localparam int FMT_PAR_LSB   = 3;
  localparam int FMT_LONG_STOP = 5;
  localparam int FMT_XBIT_EN   = 6;

  // baud_gen_control bit positions
  localparam int BGC_PS_LSB = 0;
  localparam int BGC_EN     = 6;

  // prescaler codes and ratios
  localparam logic [1:0] PS_DIV12 = 2'h0;
  localparam logic [1:0] PS_DIV4  = 2'h1;
  localparam logic [1:0] PS_DIV48 = 2'h2;
  localparam logic [1:0] PS_DIV1  = 2'h3;
  localparam logic [5:0] RATIO_1  = 6'h01;
  localparam logic [5:0] RATIO_4  = 6'h04;
  localparam logic [5:0] RATIO_12 = 6'h0C;
  localparam logic [5:0] RATIO_48 = 6'h30;

  // parity kinds
  localparam logic [1:0] PAR_ODD   = 2'h0;
  localparam logic [1:0] PAR_EVEN  = 2'h1;
  localparam logic [1:0] PAR_MARK  = 2'h2;
  localparam logic [1:0] PAR_SPACE = 2'h3;

  // reset values and timer maximum
  localparam logic [7:0]  FMT_RST  = 8'h03;
  localparam logic [7:0]  BAUD_RST = 8'h00;
  localparam logic [15:0] RLD_RST  = 16'h0000;
  localparam logic [15:0] TMR_MAX  = 16'hFFFF;

  // half-bit counts and data length base
  localparam logic [2:0] HALF_BIT   = 3'h2;
  localparam logic [2:0] STOP_LONG5 = 3'h3;
  localparam logic [2:0] STOP_LONG  = 3'h4;
  localparam logic [2:0] LEN_BASE   = 3'h4;

  localparam int RX_DEPTH = 3;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_START = 5'h02,
    ST_DATA  = 5'h04,
    ST_PAR   = 5'h08,
    ST_STOP  = 5'h10
  } asp_frm_st_t;

endpackage : asp_pkg

/* File: design/asp_baud_gen.sv */
// prescaled 16-bit reload timer giving one pulse per half bit
// assumes reload and prescaler select are stable register values
`timescale 1ns/100ps
module asp_baud_gen #(
  parameter int TMR_W = 16
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // configuration
  input  wire logic             gen_en,
  input  wire logic [1:0]       presc_sel,
  input  wire logic [TMR_W-1:0] reload,
  // half-bit pulse
  output logic                  half_tick
);

  logic [5:0]       ps_cnt_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic             ovf_ff;
  logic [5:0]       ratio;
  logic             ps_tick;

  always_comb
  begin
    case (presc_sel)
      asp_pkg::PS_DIV4:  ratio = asp_pkg::RATIO_4;
      asp_pkg::PS_DIV48: ratio = asp_pkg::RATIO_48;
      asp_pkg::PS_DIV1:  ratio = asp_pkg::RATIO_1;
      default:           ratio = asp_pkg::RATIO_12;
    endcase
  end

  assign ps_tick = (ps_cnt_ff == ratio - 6'h01); // R10

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      ps_cnt_ff <= 6'h00;
    else if (clk_en)
      ps_cnt_ff <= (!gen_en || ps_tick) ? 6'h00 : ps_cnt_ff + 6'h01; // R9
  end

  // disabled timer sits at the reload value so it starts a full period
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      tmr_ff <= '0;
      ovf_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      ovf_ff <= gen_en && ps_tick && (tmr_ff == TMR_W'(asp_pkg::TMR_MAX));
      if (!gen_en)
        tmr_ff <= reload;
      else if (ps_tick)
        tmr_ff <= (tmr_ff == TMR_W'(asp_pkg::TMR_MAX)) ? reload : tmr_ff + 1'b1; // R14 R15
    end
  end

  assign half_tick = ovf_ff;

  chk_reload_on_wrap: assert property (@(posedge clock) disable iff (sys_rst) // R15
    clk_en && gen_en && ps_tick && tmr_ff == TMR_W'(asp_pkg::TMR_MAX)
    |=> tmr_ff == $past(reload) && half_tick)
    else $error("timer did not reload on wrap");

  chk_presc_gap: assert property (@(posedge clock) disable iff (sys_rst) // R10
    clk_en && gen_en && ps_tick && presc_sel == asp_pkg::PS_DIV4 ##1 clk_en && gen_en
    |-> !ps_tick)
    else $error("prescaler ticked too soon");

endmodule : asp_baud_gen

/* File: design/asp_rx_fifo.sv */
// small receive queue, oldest entry shown at the head
// assumes push is refused by the caller when full
`timescale 1ns/100ps
module asp_rx_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 3
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       sys_rst,
  input  wire logic                       clk_en,
  // fill side
  input  wire logic                       push,
  input  wire logic [W-1:0]               push_data,
  // drain side
  input  wire logic                       pop,
  output logic      [W-1:0]               head,
  // state
  output logic                            full,
  output logic                            empty,
  output logic      [$clog2(DEPTH+1)-1:0] count
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH+1);

  logic [W-1:0]     mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic             do_push;
  logic             do_pop;

  assign do_push = clk_en && push && !full; // R2
  assign do_pop  = clk_en && pop && !empty;

  always_ff @(posedge clock)
  begin
    if (do_push)
      mem_ff[wr_ptr_ff] <= push_data;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_ff <= (wr_ptr_ff == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (do_pop)
        rd_ptr_ff <= (rd_ptr_ff == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      if (do_push && !do_pop)
        cnt_ff <= cnt_ff + 1'b1;
      else if (do_pop && !do_push)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end

  assign head  = empty ? '0 : mem_ff[rd_ptr_ff];
  assign full  = (cnt_ff == CNT_W'(DEPTH));
  assign empty = (cnt_ff == '0);
  assign count = cnt_ff;

endmodule : asp_rx_fifo

/* File: design/asp_serial_port.sv */
// second serial port: registers, transmitter and receiver
// assumes serial input already synchronous to clock
//
// Overview of operation
// R1: transmitter and receiver run independently and at the same time.
// R2: received bytes queue in a three-entry FIFO; loss only when full.
// R3: writing the data port always loads the transmit holding register.
// R4: reading the data port returns the oldest queued byte; holding register unreadable.
// R5: transmit-done flag sets per finished frame and requests interrupt when enabled.
// R6: receive-available flag sets per received byte and requests interrupt when enabled.
// R7: hardware never clears the flags; software clears each one.
// R8: clearing receive-available is ignored while the FIFO still holds bytes.
// R9: a dedicated 16-bit timer, prescaled from the system clock, times bits.
// R10: prescaler divides by 1, 4, 12 or 48, chosen in baud control.
// R11: baud control holds generator enable and prescaler select.
// R12: no transfer proceeds unless the baud generator is enabled.
// R13: high and low reload registers form the 16-bit reload value.
// R14: timer counts up by one each prescaled tick from the reload value.
// R15: on wrap from maximum to zero the timer reloads.
// R16: bit rate is clock over (65536 minus reload), halved, over prescaler.
// R17: software should keep bit rate at or below clock over sixteen.
// R18: frame is low start bit, data LSB first, high stop bits.
// R19: data length is five to eight bits.
// R20: parity even, odd, mark or space generated and checked.
// R21: extra bit unavailable with parity; long stop is 1.5 bits for five bits.
// R22: byte arriving with FIFO full is dropped and overrun flag set.
// R23: a loaded holding register starts a frame on the next bit boundary.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/100ps
module asp_serial_port (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // serial lines
  input  wire logic       ser_rx,
  output logic            ser_tx,
  // interrupt request
  output logic            irq_req
);

  logic [7:0]  fmt_ff;
  logic [7:0]  baud_ctl_ff;
  logic [15:0] rld_ff;
  logic        rx_avail_ff;
  logic        tx_done_ff;
  logic        rx_en_ff;
  logic        tx_xbit_ff;
  logic        rx_xbit_ff;
  logic        par_err_ff;
  logic        overrun_ff;
  logic        irq_en_ff;
  logic [7:0]  thr_ff;
  logic        thr_full_ff;
  logic [7:0]  rdata_ff;
  logic        phase_ff;

  asp_pkg::asp_frm_st_t tx_st_ff;
  logic [2:0]  tx_cnt_ff;
  logic [2:0]  tx_idx_ff;
  logic [7:0]  tx_shift_ff;
  logic        tx_acc_ff;
  logic        tx_line_ff;

  asp_pkg::asp_frm_st_t rx_st_ff;
  logic [2:0]  rx_cnt_ff;
  logic [2:0]  rx_idx_ff;
  logic [7:0]  rx_data_ff;
  logic        rx_acc_ff;
  logic        rx_perr_ff;
  logic        rx_xb_ff;

  logic        half_tick;
  logic        tick;
  logic [7:0]  fifo_head;
  logic        fifo_full;
  logic        fifo_empty;
  logic [1:0]  fifo_count;
  logic [2:0]  len_last;
  logic [2:0]  stop_len;
  logic        par_en;
  logic        has_xtra;
  logic        wr_data;
  logic        wr_ctrl;
  logic        rd_data;
  logic        tx_take;
  logic        tx_end;
  logic        tx_act;
  logic        rx_act;
  logic        rx_done;
  logic        fifo_push;

  function automatic logic par_bit(input logic [1:0] kind, input logic acc);
    case (kind)
      asp_pkg::PAR_ODD:  par_bit = ~acc;
      asp_pkg::PAR_EVEN: par_bit = acc;
      asp_pkg::PAR_MARK: par_bit = 1'b1;
      default:           par_bit = 1'b0;
    endcase
  endfunction : par_bit

  asp_baud_gen #(
    .TMR_W (16)
  ) u_baud (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .gen_en    (baud_ctl_ff[asp_pkg::BGC_EN]), // R11 R12
    .presc_sel (baud_ctl_ff[asp_pkg::BGC_PS_LSB +: 2]), // R10
    .reload    (rld_ff), // R13
    .half_tick (half_tick)
  );

  asp_rx_fifo #(
    .W     (8),
    .DEPTH (asp_pkg::RX_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .push      (fifo_push),
    .push_data (rx_data_ff),
    .pop       (rd_data),
    .head      (fifo_head),
    .full      (fifo_full),
    .empty     (fifo_empty),
    .count     (fifo_count)
  );

  // frame shape from the format register
  assign len_last = {1'b0, fmt_ff[asp_pkg::FMT_LEN_LSB +: 2]} + asp_pkg::LEN_BASE; // R19
  assign par_en   = fmt_ff[asp_pkg::FMT_PAR_EN];
  assign has_xtra = par_en || fmt_ff[asp_pkg::FMT_XBIT_EN];
  always_comb
  begin
    if (!fmt_ff[asp_pkg::FMT_LONG_STOP])
      stop_len = asp_pkg::HALF_BIT;
    else if (fmt_ff[asp_pkg::FMT_LEN_LSB +: 2] == 2'h0)
      stop_len = asp_pkg::STOP_LONG5; // R21
    else
      stop_len = asp_pkg::STOP_LONG;
  end

  assign wr_data = clk_en && reg_wr && reg_addr == asp_pkg::OFS_DATA;
  assign wr_ctrl = clk_en && reg_wr && reg_addr == asp_pkg::OFS_CTRL;
  assign rd_data = clk_en && reg_rd && reg_addr == asp_pkg::OFS_DATA; // R4

  // a bit is two timer wraps, so the halving sits here
  assign tick = clk_en && half_tick;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      phase_ff <= 1'b0;
    else if (clk_en && !baud_ctl_ff[asp_pkg::BGC_EN])
      phase_ff <= 1'b0;
    else if (tick)
      phase_ff <= ~phase_ff; // R16
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      fmt_ff      <= asp_pkg::FMT_RST;
      baud_ctl_ff <= asp_pkg::BAUD_RST;
      rld_ff      <= asp_pkg::RLD_RST;
    end
    else if (clk_en && reg_wr)
    begin
      case (reg_addr)
        asp_pkg::OFS_FMT:    fmt_ff <= reg_wdata;
        asp_pkg::OFS_BAUD:   baud_ctl_ff <= reg_wdata; // R11
        asp_pkg::OFS_RLD_LO: rld_ff[7:0] <= reg_wdata; // R13
        asp_pkg::OFS_RLD_HI: rld_ff[15:8] <= reg_wdata;
        default:             fmt_ff <= fmt_ff;
      endcase
    end
  end

  // holding register; a write in the take cycle still counts as full
  assign tx_take = tick && tx_st_ff == asp_pkg::ST_IDLE && thr_full_ff && phase_ff; // R23
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      thr_ff      <= 8'h00;
      thr_full_ff <= 1'b0;
    end
    else if (wr_data)
    begin
      thr_ff      <= reg_wdata; // R3
      thr_full_ff <= 1'b1;
    end
    else if (tx_take)
      thr_full_ff <= 1'b0;
  end

  // flags: hardware sets, software writes zero, set wins over clear
  assign tx_end    = tick && tx_st_ff == asp_pkg::ST_STOP && tx_cnt_ff == 3'h1;
  assign fifo_push = rx_done && !fifo_full; // R2
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rx_avail_ff <= 1'b0;
      tx_done_ff  <= 1'b0;
      par_err_ff  <= 1'b0;
      overrun_ff  <= 1'b0;
      rx_en_ff    <= 1'b0;
      tx_xbit_ff  <= 1'b0;
      irq_en_ff   <= 1'b0;
      rx_xbit_ff  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (fifo_push)
        rx_avail_ff <= 1'b1; // R6
      else if (wr_ctrl && !reg_wdata[asp_pkg::CTL_RX_AVAIL] && fifo_empty)
        rx_avail_ff <= 1'b0; // R7 R8
      if (tx_end)
        tx_done_ff <= 1'b1; // R5
      else if (wr_ctrl && !reg_wdata[asp_pkg::CTL_TX_DONE])
        tx_done_ff <= 1'b0; // R7
      if (fifo_push && rx_perr_ff)
        par_err_ff <= 1'b1; // R20
      else if (wr_ctrl && !reg_wdata[asp_pkg::CTL_PAR_ERR])
        par_err_ff <= 1'b0;
      if (rx_done && fifo_full)
        overrun_ff <= 1'b1; // R22
      else if (wr_ctrl && !reg_wdata[asp_pkg::CTL_OVERRUN])
        overrun_ff <= 1'b0;
      if (fifo_push)
        rx_xbit_ff <= rx_xb_ff;
      if (wr_ctrl)
      begin
        rx_en_ff   <= reg_wdata[asp_pkg::CTL_RX_EN];
        tx_xbit_ff <= reg_wdata[asp_pkg::CTL_TX_XBIT];
        irq_en_ff  <= reg_wdata[asp_pkg::CTL_IRQ_EN];
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rdata_ff <= 8'h00;
    else if (clk_en)
    begin
      if (!reg_rd)
        rdata_ff <= 8'h00;
      else
        case (reg_addr)
          asp_pkg::OFS_DATA:   rdata_ff <= fifo_head; // R4
          asp_pkg::OFS_CTRL:   rdata_ff <= {irq_en_ff, overrun_ff, par_err_ff, rx_xbit_ff,
                                            tx_xbit_ff, rx_en_ff, tx_done_ff, rx_avail_ff};
          asp_pkg::OFS_FMT:    rdata_ff <= fmt_ff;
          asp_pkg::OFS_BAUD:   rdata_ff <= baud_ctl_ff;
          asp_pkg::OFS_RLD_LO: rdata_ff <= rld_ff[7:0];
          asp_pkg::OFS_RLD_HI: rdata_ff <= rld_ff[15:8];
          default:             rdata_ff <= 8'h00;
        endcase
    end
  end

  // transmitter, stepping in half bits
  assign tx_act = tick && tx_cnt_ff == 3'h1;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      tx_st_ff    <= asp_pkg::ST_IDLE;
      tx_cnt_ff   <= 3'h0;
      tx_idx_ff   <= 3'h0;
      tx_shift_ff <= 8'h00;
      tx_acc_ff   <= 1'b0;
      tx_line_ff  <= 1'b1;
    end
    else if (tick && tx_st_ff != asp_pkg::ST_IDLE && tx_cnt_ff != 3'h1)
      tx_cnt_ff <= tx_cnt_ff - 3'h1;
    else if (tick)
    begin
      case (tx_st_ff)
        asp_pkg::ST_IDLE:
          if (tx_take)
          begin
            tx_st_ff    <= asp_pkg::ST_START;
            tx_cnt_ff   <= asp_pkg::HALF_BIT;
            tx_shift_ff <= thr_ff;
            tx_acc_ff   <= 1'b0;
            tx_line_ff  <= 1'b0; // R18
          end
        asp_pkg::ST_START:
        begin
          tx_st_ff    <= asp_pkg::ST_DATA;
          tx_cnt_ff   <= asp_pkg::HALF_BIT;
          tx_idx_ff   <= 3'h0;
          tx_line_ff  <= tx_shift_ff[0]; // R18
          tx_acc_ff   <= tx_shift_ff[0];
          tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
        end
        asp_pkg::ST_DATA:
          if (tx_idx_ff == len_last && has_xtra)
          begin
            tx_st_ff   <= asp_pkg::ST_PAR;
            tx_cnt_ff  <= asp_pkg::HALF_BIT;
            tx_line_ff <= par_en ? par_bit(fmt_ff[asp_pkg::FMT_PAR_LSB +: 2], tx_acc_ff)
                                 : tx_xbit_ff; // R20 R21
          end
          else if (tx_idx_ff == len_last)
          begin
            tx_st_ff   <= asp_pkg::ST_STOP;
            tx_cnt_ff  <= stop_len;
            tx_line_ff <= 1'b1;
          end
          else
          begin
            tx_cnt_ff   <= asp_pkg::HALF_BIT;
            tx_idx_ff   <= tx_idx_ff + 3'h1;
            tx_line_ff  <= tx_shift_ff[0];
            tx_acc_ff   <= tx_acc_ff ^ tx_shift_ff[0];
            tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
          end
        asp_pkg::ST_PAR:
        begin
          tx_st_ff   <= asp_pkg::ST_STOP;
          tx_cnt_ff  <= stop_len;
          tx_line_ff <= 1'b1; // R18
        end
        default:
        begin
          tx_st_ff   <= asp_pkg::ST_IDLE;
          tx_line_ff <= 1'b1;
        end
      endcase
    end
  end

  // receiver; sampling rides the free half-bit pulse, so the sample
  // point may sit up to half a bit off centre
  assign rx_act  = tick && rx_cnt_ff == 3'h1;
  assign rx_done = rx_act && rx_st_ff == asp_pkg::ST_STOP;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rx_st_ff   <= asp_pkg::ST_IDLE;
      rx_cnt_ff  <= 3'h0;
      rx_idx_ff  <= 3'h0;
      rx_data_ff <= 8'h00;
      rx_acc_ff  <= 1'b0;
      rx_perr_ff <= 1'b0;
      rx_xb_ff   <= 1'b0;
    end
    else if (tick && rx_st_ff != asp_pkg::ST_IDLE && rx_cnt_ff != 3'h1)
      rx_cnt_ff <= rx_cnt_ff - 3'h1;
    else if (tick)
    begin
      case (rx_st_ff)
        asp_pkg::ST_IDLE:
          if (rx_en_ff && !ser_rx) // R1
          begin
            rx_st_ff  <= asp_pkg::ST_START;
            rx_cnt_ff <= 3'h1;
          end
        asp_pkg::ST_START:
          if (!ser_rx) // R18
          begin
            rx_st_ff   <= asp_pkg::ST_DATA;
            rx_cnt_ff  <= asp_pkg::HALF_BIT;
            rx_idx_ff  <= 3'h0;
            rx_data_ff <= 8'h00;
            rx_acc_ff  <= 1'b0;
            rx_perr_ff <= 1'b0;
            rx_xb_ff   <= 1'b0;
          end
          else
            rx_st_ff <= asp_pkg::ST_IDLE;
        asp_pkg::ST_DATA:
        begin
          rx_data_ff[rx_idx_ff] <= ser_rx; // R18 R19
          rx_acc_ff <= rx_acc_ff ^ ser_rx;
          rx_cnt_ff <= asp_pkg::HALF_BIT;
          rx_idx_ff <= rx_idx_ff + 3'h1;
          if (rx_idx_ff == len_last)
            rx_st_ff <= has_xtra ? asp_pkg::ST_PAR : asp_pkg::ST_STOP;
        end
        asp_pkg::ST_PAR:
        begin
          if (par_en)
            rx_perr_ff <= ser_rx != par_bit(fmt_ff[asp_pkg::FMT_PAR_LSB +: 2], rx_acc_ff); // R20
          else
            rx_xb_ff <= ser_rx;
          rx_st_ff  <= asp_pkg::ST_STOP;
          rx_cnt_ff <= asp_pkg::HALF_BIT;
        end
        default:
          rx_st_ff <= asp_pkg::ST_IDLE;
      endcase
    end
  end

  assign ser_tx    = tx_line_ff;
  assign reg_rdata = rdata_ff;
  assign irq_req   = irq_en_ff && (rx_avail_ff || tx_done_ff); // R5 R6

  chk_idle_line_high: assert property (@(posedge clock) disable iff (sys_rst) // R18
    tx_st_ff == asp_pkg::ST_IDLE |-> ser_tx)
    else $error("line not high while idle");

  chk_start_bit_low: assert property (@(posedge clock) disable iff (sys_rst) // R18
    tx_st_ff == asp_pkg::ST_START |-> !ser_tx)
    else $error("start bit not low");

  chk_write_loads_thr: assert property (@(posedge clock) disable iff (sys_rst) // R3
    wr_data |=> thr_full_ff && thr_ff == $past(reg_wdata) && fifo_count == $past(fifo_count)
                || $past(rd_data) || $past(fifo_push))
    else $error("data write did not load holding register");

  chk_read_oldest: assert property (@(posedge clock) disable iff (sys_rst) // R4
    rd_data |=> reg_rdata == $past(fifo_head))
    else $error("data read not oldest byte");

  chk_overrun_drop: assert property (@(posedge clock) disable iff (sys_rst) // R22
    rx_done && fifo_full && !rd_data |=> overrun_ff && fifo_count == $past(fifo_count))
    else $error("overrun not flagged or queue changed");

  chk_rx_clear_held: assert property (@(posedge clock) disable iff (sys_rst) // R8
    wr_ctrl && !reg_wdata[asp_pkg::CTL_RX_AVAIL] && !fifo_empty && rx_avail_ff |=> rx_avail_ff)
    else $error("receive flag cleared with bytes left");

  chk_tx_done_sets: assert property (@(posedge clock) disable iff (sys_rst) // R5
    tx_end |=> tx_done_ff && tx_st_ff == asp_pkg::ST_IDLE)
    else $error("transmit done flag not set");

  chk_rx_avail_irq: assert property (@(posedge clock) disable iff (sys_rst) // R6
    fifo_push && irq_en_ff && !wr_ctrl |=> rx_avail_ff && irq_req)
    else $error("receive flag or request missing");

  chk_start_on_phase: assert property (@(posedge clock) disable iff (sys_rst) // R23
    tx_take |-> phase_ff ##1 tx_st_ff == asp_pkg::ST_START && !thr_full_ff || $past(wr_data))
    else $error("frame started off a bit boundary");

  cov_tx_frame: cover property (@(posedge clock) disable iff (sys_rst) tx_end);
  cov_rx_push:  cover property (@(posedge clock) disable iff (sys_rst) fifo_push);
  cov_overrun:  cover property (@(posedge clock) disable iff (sys_rst) rx_done && fifo_full);
  cov_clr_held: cover property (@(posedge clock) disable iff (sys_rst)
    wr_ctrl && !reg_wdata[asp_pkg::CTL_RX_AVAIL] && !fifo_empty);

endmodule : asp_serial_port

/* File: verif/asp_remote_node.sv */
// remote serial node: sends frames on rx, captures frames from tx
// assumes ten-bit frames at sixteen clocks per bit
`timescale 1ns/100ps
module asp_remote_node (
  // clock
  input  wire logic       clock,
  // serial lines
  input  wire logic       ser_tx,
  output logic            ser_rx,
  // capture
  output logic      [7:0] got_byte,
  output int              got_cnt
);
  initial
  begin
    ser_rx   = 1'b1;
    got_cnt  = 0;
    got_byte = 8'h00;
  end

  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
      repeat (16) @(posedge clock) ser_rx <= f[i];
  endtask : send

  // sample on the falling edge, clear of the tx register update
  always
  begin
    @(negedge clock iff ser_tx === 1'b0);
    repeat (8) @(negedge clock);
    for (int i = 0; i < 8; i++)
    begin
      repeat (16) @(negedge clock);
      got_byte[i] = ser_tx;
    end
    repeat (16) @(negedge clock);
    if (ser_tx === 1'b1)
      got_cnt++;
  end
endmodule : asp_remote_node

/* File: verif/asp_serial_port_bench.sv */
// self-checking bench of the second serial port
// assumes one clock and the remote node model on the lines
`timescale 1ns/100ps
module asp_serial_port_bench;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       ser_rx;
  logic       ser_tx;
  logic       irq_req;
  logic [7:0] got_byte;
  logic [7:0] rd_val;
  int         got_cnt;
  int         miscompares = 0;
  int         num_checks = 0;
  int         cycles = 0;

  always #10 clock = ~clock;

  asp_serial_port dut_u (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ser_rx(ser_rx), .ser_tx(ser_tx), .irq_req(irq_req));
  asp_remote_node node_u (.clock(clock), .ser_tx(ser_tx), .ser_rx(ser_rx),
    .got_byte(got_byte), .got_cnt(got_cnt));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // tests need about thirteen hundred cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(asp_pkg::OFS_CTRL);
    chk(rd_val, 8'h00, "ctrl reset");
    rd(asp_pkg::OFS_FMT);
    chk(rd_val, asp_pkg::FMT_RST, "fmt reset");
    rd(3'h6);
    chk(rd_val, 8'h00, "unmapped");
    $display("test reset done");
    wr(asp_pkg::OFS_CTRL, 8'h84);
    wr(asp_pkg::OFS_DATA, 8'hA5);
    repeat (40) @(posedge clock);
    chk(8'(got_cnt), 8'h00, "frames while off");
    wr(asp_pkg::OFS_RLD_LO, 8'hFE);
    wr(asp_pkg::OFS_RLD_HI, 8'hFF);
    // divide by four: sixteen clocks a bit, no faster than advised
    wr(asp_pkg::OFS_BAUD, 8'h41);
    // transmit and receive at once; generator runs before the start bit
    // so the receiver catches it early enough
    node_u.send(8'h5A);
    for (int i = 0; i < 200 && got_cnt == 0; i++)
      @(posedge clock);
    repeat (16) @(posedge clock);
    chk(got_byte, 8'hA5, "tx byte");
    chk({7'h00, irq_req}, 8'h01, "irq");
    rd(asp_pkg::OFS_CTRL);
    chk(rd_val, 8'h87, "ctrl both flags");
    rd(asp_pkg::OFS_DATA);
    chk(rd_val, 8'h5A, "rx byte");
    wr(asp_pkg::OFS_CTRL, 8'h84);
    rd(asp_pkg::OFS_CTRL);
    chk(rd_val, 8'h84, "flags cleared");
    chk({7'h00, irq_req}, 8'h00, "irq off");
    $display("test duplex done");
    for (int i = 1; i < 5; i++)
      node_u.send(8'(i * 17));
    repeat (12) @(posedge clock);
    rd(asp_pkg::OFS_CTRL);
    chk(rd_val, 8'hC5, "ctrl overrun");
    wr(asp_pkg::OFS_CTRL, 8'h84);
    rd(asp_pkg::OFS_CTRL);
    chk(rd_val, 8'h85, "avail held");
    for (int i = 1; i < 4; i++)
    begin
      rd(asp_pkg::OFS_DATA);
      chk(rd_val, 8'(i * 17), "fifo order");
    end
    wr(asp_pkg::OFS_CTRL, 8'h84);
    rd(asp_pkg::OFS_CTRL);
    chk(rd_val, 8'h84, "avail cleared");
    $display("test fifo done");
    // seven bits with even parity still make a ten-bit frame
    wr(asp_pkg::OFS_FMT, 8'h0E);
    wr(asp_pkg::OFS_DATA, 8'h15);
    node_u.send(8'h95);
    for (int i = 0; i < 200 && got_cnt < 2; i++)
      @(posedge clock);
    repeat (16) @(posedge clock);
    chk(got_byte, 8'h95, "tx even parity");
    rd(asp_pkg::OFS_DATA);
    chk(rd_val, 8'h15, "rx seven bits");
    node_u.send(8'h15);
    repeat (16) @(posedge clock);
    rd(asp_pkg::OFS_CTRL);
    chk(rd_val, 8'hA7, "parity error");
    $display("test parity done");
    tally_and_finish();
  end
endmodule : asp_serial_port_bench
